// ---- verilog/ivc_controller.sv ----
// interrupt vector controller: merges traps and interrupt requests into one cpu request
// and hands the cpu a vector address after a fixed entry latency
// assumes sources are synchronous to clk and drop their request after their ack pulse
`timescale 1ns/1ps

// What this block does
// (R1) all peripheral requests merge into one registered request toward the cpu
// (R2) seven user levels; level must exceed the cpu's current level to win
// (R3) up to eight trap slots, taken ahead of every ordinary interrupt
// (R4) vector area starts at word 000004h: 8 trap then 118 interrupt slots
// (R5) each vector address handed out is 24 bits wide
// (R6) lower table position outranks higher position among traps and within one user level
// (R7) equal user level resolved by fixed lowest index
// (R8) every source has its own vector slot
// (R9) only 20 interrupts and 4 traps are implemented; other slots ignored
// (R10) entry and return each take a fixed cycle count
// (R11) alternate table select moves every trap and interrupt vector into the alternate table
// (R12) alternate table keeps the same slot layout as the primary table
// (R13) reset bypasses arbitration; execution starts at address 0x000000
// (R14) trap slots from 0x000004: reserved, oscillator, address, stack, math, reserved
// (R15) interrupt 0 at 0x000014 primary, 0x000114 alternate
// (R16) reset goto at 0x000000, target at 0x000002, code from 0x000200
// (R17) vector address is table vector-0 base plus twice the request number
module ivc_controller #(
    parameter int NUM_IRQ = 118,
    parameter logic [NUM_IRQ-1:0] IRQ_IMPL_MASK = ivc_pkg::IRQ_IMPL[NUM_IRQ-1:0]
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // interrupt sources
    input wire logic [NUM_IRQ-1:0] irq_req,
    input wire logic [NUM_IRQ-1:0][2:0] irq_level,
    output logic irq_ack,
    // trap sources
    input wire logic [7:0] trap_req,
    output logic trap_ack,
    output logic [6:0] ack_idx,
    // configuration
    input wire logic alternate_table_select,
    // cpu side
    input wire logic [2:0] cpu_prio,
    input wire logic cpu_ack,
    input wire logic cpu_return,
    output logic cpu_irq,
    output logic vec_valid,
    output logic [23:0] vec_addr,
    output logic vec_is_trap,
    output logic vec_is_reset,
    output logic [6:0] vec_idx,
    output logic ret_done,
    output logic busy
);

    if (NUM_IRQ < 1 || NUM_IRQ > ivc_pkg::IRQ_MAX)
    begin : g_chk
        $error("ivc_controller: NUM_IRQ out of range");
    end

    localparam int ENTRY_LAT = int'(ivc_pkg::ENTRY_CYCLES);
    localparam int RET_LAT = int'(ivc_pkg::RETURN_CYCLES);
    // checks sample one edge after a registered pulse appears, so they look one cycle further
    localparam int ENTRY_SEEN = ENTRY_LAT + 1;
    localparam int RET_SEEN = RET_LAT + 1;

    ivc_pkg::ivc_state_t s;
    ivc_pkg::ivc_state_t next_s;

    logic arb_found;
    logic [6:0] arb_idx;
    logic [2:0] arb_lvl;
    logic [7:0] trap_pend;
    logic trap_any;
    logic [2:0] trap_idx;

    ivc_level_arb #(
        .N(NUM_IRQ),
        .IMPL(IRQ_IMPL_MASK)
    ) u_arb (
        .req(irq_req),
        .level(irq_level),
        .found(arb_found),
        .idx(arb_idx),
        .lvl(arb_lvl)
    );

    // only implemented trap slots count; reserved slots are dropped here
    assign trap_pend = trap_req & ivc_pkg::TRAP_IMPL; // (R9)

    // lowest trap slot first
    always_comb
    begin
        trap_any = 1'b0;
        trap_idx = 3'h0;
        for (int i = ivc_pkg::TRAP_NUM - 1; i >= 0; i--)
        begin
            if (trap_pend[i])
            begin
                trap_any = 1'b1; // (R3)
                trap_idx = 3'(i); // (R6)
            end
        end
    end

    always_comb
    begin
        next_s = s;
        next_s.vec_valid = 1'b0;
        next_s.irq_ack = 1'b0;
        next_s.trap_ack = 1'b0;
        next_s.ret_done = 1'b0;
        next_s.win = '0;
        // traps sit above every user level and are not maskable
        if (trap_any)
        begin
            next_s.win.found = 1'b1; // (R3)
            next_s.win.is_trap = 1'b1;
            next_s.win.idx = {4'h0, trap_idx}; // (R14)
            next_s.win.lvl = 3'h7;
        end
        else if (arb_found && arb_lvl > cpu_prio)
        begin
            next_s.win.found = 1'b1; // (R2)
            next_s.win.idx = arb_idx; // (R7)
            next_s.win.lvl = arb_lvl;
        end
        unique case (s.phase)
            ivc_pkg::ST_BOOT:
            begin
                // first cycle after reset points the cpu at the reset goto, no arbitration
                next_s.vec_valid = 1'b1; // (R13)
                next_s.vec_addr = ivc_pkg::RESET_GOTO_ADDR; // (R16)
                next_s.vec_is_reset = 1'b1;
                next_s.phase = ivc_pkg::ST_IDLE;
            end
            ivc_pkg::ST_IDLE:
            begin
                next_s.irq_out = next_s.win.found; // (R1)
                // the request and the winner were registered together, so the ack takes that winner
                if (cpu_ack && s.irq_out)
                begin
                    next_s.taken = s.win;
                    next_s.irq_out = 1'b0;
                    next_s.irq_ack = !s.win.is_trap;
                    next_s.trap_ack = s.win.is_trap;
                    next_s.ack_idx = s.win.idx; // (R8)
                    next_s.cnt = ivc_pkg::ENTRY_CYCLES - 4'h1; // (R10)
                    next_s.busy = 1'b1;
                    next_s.phase = ivc_pkg::ST_ENTRY;
                end
            end
            ivc_pkg::ST_ENTRY:
            begin
                if (s.cnt == 4'h0)
                begin
                    // table select is sampled when the vector is formed
                    next_s.vec_valid = 1'b1;
                    next_s.vec_addr = ivc_pkg::ivc_vec_addr(alternate_table_select,
                        s.taken.is_trap, s.taken.idx); // (R17)
                    next_s.vec_is_trap = s.taken.is_trap;
                    next_s.vec_is_reset = 1'b0;
                    next_s.vec_idx = s.taken.idx;
                    next_s.phase = ivc_pkg::ST_SERVICE;
                end
                else
                begin
                    next_s.cnt = s.cnt - 4'h1; // (R10)
                end
            end
            ivc_pkg::ST_SERVICE:
            begin
                // no nesting: a newer request waits until the return completes
                if (cpu_return)
                begin
                    next_s.cnt = ivc_pkg::RETURN_CYCLES - 4'h1; // (R10)
                    next_s.phase = ivc_pkg::ST_RETURN;
                end
            end
            ivc_pkg::ST_RETURN:
            begin
                if (s.cnt == 4'h0)
                begin
                    next_s.ret_done = 1'b1;
                    next_s.busy = 1'b0;
                    next_s.phase = ivc_pkg::ST_IDLE;
                end
                else
                begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            default:
            begin
                next_s.phase = ivc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s <= ivc_pkg::STATE_RESET; // (R13)
        end
        else
        begin
            s <= next_s;
        end
    end

    assign cpu_irq = s.irq_out;
    assign vec_valid = s.vec_valid;
    assign vec_addr = s.vec_addr;
    assign vec_is_trap = s.vec_is_trap;
    assign vec_is_reset = s.vec_is_reset;
    assign vec_idx = s.vec_idx;
    assign irq_ack = s.irq_ack;
    assign trap_ack = s.trap_ack;
    assign ack_idx = s.ack_idx;
    assign ret_done = s.ret_done;
    assign busy = s.busy;

    // helper for the tie check: any eligible lower index at an equal or higher level
    logic tie_bad;

    always_comb
    begin
        tie_bad = 1'b0;
        for (int j = 0; j < NUM_IRQ; j++)
        begin
            if (arb_found && 7'(j) < arb_idx && IRQ_IMPL_MASK[j] && irq_req[j]
                && irq_level[j] != 3'h0 && irq_level[j] >= arb_lvl)
            begin
                tie_bad = 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!rstn);

    sequence seq_take;
        s.phase == ivc_pkg::ST_IDLE && cpu_ack && cpu_irq;
    endsequence

    sequence seq_ret_req;
        s.phase == ivc_pkg::ST_SERVICE && cpu_return;
    endsequence

    sequence seq_trap_wait;
        s.phase == ivc_pkg::ST_IDLE && !cpu_ack && trap_any;
    endsequence

    AST_ENTRY_LAT: assert property (seq_take |-> ##ENTRY_SEEN (vec_valid && !vec_is_reset)) // (R10)
        else $error("vector not delivered after the fixed entry latency");

    AST_RET_LAT: assert property (seq_ret_req |-> ##RET_SEEN (ret_done && !busy)) // (R10)
        else $error("return not completed after the fixed return latency");

    AST_TRAP_REQ: assert property (seq_trap_wait |=> cpu_irq) // (R1)
        else $error("pending trap did not raise the cpu request");

    AST_TRAP_FIRST: assert property (seq_trap_wait |=> (s.win.is_trap && s.win.idx[2:0] == $past(trap_idx))) // (R3)
        else $error("trap did not outrank interrupts or wrong trap slot chosen");

    AST_LEVEL_GATE: assert property ((s.win.found && !s.win.is_trap)
        |-> (s.win.lvl > $past(cpu_prio) && s.win.lvl != 3'h0)) // (R2)
        else $error("interrupt won without exceeding the cpu level");

    AST_TIE_ORDER: assert property (arb_found |-> !tie_bad) // (R7)
        else $error("lower index at equal level was passed over");

    AST_VEC_IRQ: assert property ((vec_valid && !vec_is_reset && !vec_is_trap)
        |-> (vec_addr == ivc_pkg::VEC0_BASE + {16'h0000, vec_idx, 1'b0}
            + ($past(alternate_table_select) ? ivc_pkg::ALT_OFFSET : 24'h000000))) // (R15)
        else $error("interrupt vector address not base plus twice the request number");

    AST_VEC_RANGE: assert property ((vec_valid && !vec_is_reset)
        |-> (vec_addr > ivc_pkg::RESET_TARGET_ADDR && vec_addr < ivc_pkg::CODE_START
            && vec_addr[0] == 1'b0)) // (R4)
        else $error("vector address outside the vector tables");

    AST_ALT_SELECT: assert property ((vec_valid && !vec_is_reset)
        |-> (vec_addr >= ivc_pkg::ALT_OFFSET) == $past(alternate_table_select)) // (R11)
        else $error("vector taken from the wrong table");

    AST_BOOT: assert property ($rose(rstn) |=> (vec_valid && vec_is_reset
        && vec_addr == ivc_pkg::RESET_GOTO_ADDR && !cpu_irq)) // (R13)
        else $error("reset did not point the cpu at address zero");

    AST_ACK_PAIR: assert property ((irq_ack || trap_ack)
        |-> ##ENTRY_LAT (vec_valid && vec_idx == ack_idx
            && vec_is_trap == $past(trap_ack, ENTRY_LAT))) // (R8)
        else $error("vector does not belong to the acknowledged source");

    AST_IMPL_ONLY: assert property ((irq_ack |-> IRQ_IMPL_MASK[ack_idx])
        and (trap_ack |-> ivc_pkg::TRAP_IMPL[ack_idx[2:0]])) // (R9)
        else $error("unimplemented slot acknowledged");

    // idle with no take: the registered request must follow what is eligible right now
    sequence seq_irq_wait;
        s.phase == ivc_pkg::ST_IDLE && !cpu_ack && !trap_any && arb_found && arb_lvl > cpu_prio;
    endsequence

    sequence seq_none_wait;
        s.phase == ivc_pkg::ST_IDLE && !cpu_ack && !trap_any && !(arb_found && arb_lvl > cpu_prio);
    endsequence

    AST_IRQ_WIN: assert property (seq_irq_wait |=> (cpu_irq && !s.win.is_trap && s.win.idx == $past(arb_idx))) // (R1)
        else $error("pending interrupt did not raise the cpu request");

    AST_NONE_QUIET: assert property (seq_none_wait |=> !cpu_irq) // (R9)
        else $error("cpu request raised with nothing eligible pending");

    AST_BUSY_QUIET: assert property (busy |-> !cpu_irq) // (R10)
        else $error("cpu request raised while an entry or return is under way");

    AST_TAKE_BUSY: assert property (seq_take |=> (busy && !cpu_irq)) // (R10)
        else $error("take did not drop the request and mark the controller busy");

    // repetition counts equal ENTRY_CYCLES and RETURN_CYCLES and must be kept in step with them
    AST_ENTRY_QUIET: assert property (seq_take |=> (!vec_valid && busy)[*4]) // (R10)
        else $error("vector appeared before the fixed entry latency");

    AST_RET_QUIET: assert property (seq_ret_req |=> (!ret_done && busy)[*3]) // (R10)
        else $error("return completed before the fixed return latency");

    AST_ACK_PULSE: assert property ((irq_ack || trap_ack)
        |-> (irq_ack != trap_ack) ##1 (!irq_ack && !trap_ack && busy)) // (R8)
        else $error("acknowledge not a single one-cycle pulse of one kind");

    AST_VEC_TRAP: assert property ((vec_valid && vec_is_trap)
        |-> (vec_addr == ivc_pkg::TRAP_BASE + {16'h0000, vec_idx, 1'b0}
            + ($past(alternate_table_select) ? ivc_pkg::ALT_OFFSET : 24'h000000))) // (R14)
        else $error("trap vector address not trap base plus twice the slot");

endmodule

// ---- verilog/ivc_pkg.sv ----
// shared constants, types and the vector address function for the interrupt vector controller
// assumes one 100 MHz clock and a synchronous active-low reset in every user
package ivc_pkg;

    // source counts and field widths
    localparam int IRQ_MAX = 118;
    localparam int TRAP_NUM = 8;
    localparam int LVL_W = 3;
    localparam int IDX_W = 7;
    localparam int ADDR_W = 24;
    localparam int CNT_W = 4;

    // program memory word addresses of the vector area
    localparam logic [23:0] RESET_GOTO_ADDR = 24'h000000;
    localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
    localparam logic [23:0] TRAP_BASE = 24'h000004;
    localparam logic [23:0] VEC0_BASE = 24'h000014;
    localparam logic [23:0] ALT_OFFSET = 24'h000100;
    localparam logic [23:0] CODE_START = 24'h000200;

    // trap slots: 0 reserved, 1 oscillator fail, 2 address error, 3 stack error, 4 math error, 5..7 reserved
    localparam logic [7:0] TRAP_IMPL = 8'h1e;
    localparam logic [2:0] TRAP_OSC_FAIL = 3'h1;
    localparam logic [2:0] TRAP_ADDR_ERR = 3'h2;
    localparam logic [2:0] TRAP_STACK_ERR = 3'h3;
    localparam logic [2:0] TRAP_MATH_ERR = 3'h4;

    // implemented interrupt request numbers of this variant
    localparam logic [117:0] IRQ_IMPL = 118'h20db3fef;

    // fixed latencies in clock cycles, independent of source
    localparam logic [3:0] ENTRY_CYCLES = 4'h4;
    localparam logic [3:0] RETURN_CYCLES = 4'h3;

    typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_ENTRY, ST_SERVICE, ST_RETURN} ivc_phase_t;

    typedef struct packed {
        logic found;
        logic is_trap;
        logic [6:0] idx;
        logic [2:0] lvl;
    } ivc_win_t;

    typedef struct packed {
        ivc_phase_t phase;
        logic [3:0] cnt;
        ivc_win_t win;
        ivc_win_t taken;
        logic irq_out;
        logic vec_valid;
        logic [23:0] vec_addr;
        logic vec_is_trap;
        logic vec_is_reset;
        logic [6:0] vec_idx;
        logic irq_ack;
        logic trap_ack;
        logic [6:0] ack_idx;
        logic ret_done;
        logic busy;
    } ivc_state_t;

    localparam ivc_state_t STATE_RESET = '{phase: ST_BOOT, default: '0};

    // table base plus two words per slot; alternate table is the primary one shifted up
    function automatic logic [23:0] ivc_vec_addr(input logic alt, input logic is_trap, input logic [6:0] idx);
        logic [23:0] base;
        base = is_trap ? TRAP_BASE : VEC0_BASE; // (R4) (R15)
        if (alt)
        begin
            base = base + ALT_OFFSET; // (R11) (R12)
        end
        return base + {16'h0000, idx, 1'b0}; // (R5) (R17)
    endfunction

endpackage

// ---- verilog/ivc_level_arb.sv ----
// priority arbiter over the ordinary interrupt sources
// assumes levels 1..7 are active and 0 disables a source; purely combinational
`timescale 1ns/1ps

module ivc_level_arb #(
    parameter int N = 118,
    parameter logic [N-1:0] IMPL = '1
) (
    // requests and their user levels
    input wire logic [N-1:0] req,
    input wire logic [N-1:0][2:0] level,
    // winner
    output logic found,
    output logic [6:0] idx,
    output logic [2:0] lvl
);

    if (N < 1 || N > ivc_pkg::IRQ_MAX)
    begin : g_chk
        $error("ivc_level_arb: N out of range");
    end

    logic [N-1:0] eligible;

    // unimplemented slots can never win, whatever is driven on them
    for (genvar i = 0; i < N; i++)
    begin : g_elig
        assign eligible[i] = req[i] & IMPL[i] & (level[i] != 3'h0);
    end

    // scan from the top down with >= so the lowest index wins a tie
    always_comb
    begin
        found = 1'b0;
        idx = 7'h00;
        lvl = 3'h0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (eligible[i] && level[i] >= lvl)
            begin
                found = 1'b1;
                idx = 7'(i);
                lvl = level[i];
            end
        end
    end

endmodule

// ---- tb/ivc_cpu_model.sv ----
// cpu core model: accepts the merged request, enters service, then returns
// assumes the controller pulses vec_valid once per entry and once after reset
`timescale 1ns/1ps

module ivc_cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // controller side
    input wire logic cpu_irq,
    input wire logic vec_valid,
    input wire logic vec_is_reset,
    output logic cpu_ack,
    output logic cpu_return,
    // pacing set by the bench
    input wire logic [3:0] ack_wait,
    input wire logic [3:0] svc_len
);
    logic [3:0] wait_cnt;
    logic [3:0] svc_cnt;
    logic in_svc;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wait_cnt <= 4'h0;
            svc_cnt <= 4'h0;
            in_svc <= 1'b0;
            cpu_ack <= 1'b0;
            cpu_return <= 1'b0;
        end
        else
        begin
            // a slow core lets the request stand a while before taking it
            wait_cnt <= cpu_irq ? wait_cnt + 4'h1 : 4'h0;
            cpu_ack <= cpu_irq && (wait_cnt >= ack_wait);
            cpu_return <= 1'b0;
            // the boot pulse is not an entry, so no return follows it
            if (vec_valid && !vec_is_reset)
            begin
                in_svc <= 1'b1;
                svc_cnt <= svc_len;
            end
            else if (in_svc)
            begin
                if (svc_cnt == 4'h0)
                begin
                    cpu_return <= 1'b1;
                    in_svc <= 1'b0;
                end
                else
                begin
                    svc_cnt <= svc_cnt - 4'h1;
                end
            end
        end
    end
endmodule

// ---- tb/tb_interrupt_vector_controller.sv ----
// self-checking bench for the interrupt vector controller with a cpu model
// assumes the default 118-source build; inputs change at the falling edge
`timescale 1ns/1ps

module tb_interrupt_vector_controller;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [117:0] irq_req = '0;
    logic [117:0][2:0] irq_level = '0;
    logic [7:0] trap_req = 8'h00;
    logic alt_sel = 1'b0;
    logic [2:0] cpu_prio = 3'h0;
    logic [3:0] ack_wait = 4'h0;
    logic [3:0] svc_len = 4'h1;
    logic cpu_ack, cpu_return, irq_ack, trap_ack, cpu_irq, vec_valid;
    logic vec_is_trap, vec_is_reset, ret_done, busy;
    logic [6:0] ack_idx, vec_idx;
    logic [23:0] vec_addr;
    int err_total = 0;
    int checked = 0;
    // implemented request numbers 0..29 of this variant
    localparam logic [29:0] IMPL_SET = 30'h20db3fef;

    always #5 clk = ~clk;

    ivc_controller u_ivc_controller (.clk(clk), .rstn(rstn), .irq_req(irq_req), .irq_level(irq_level),
        .irq_ack(irq_ack), .trap_req(trap_req), .trap_ack(trap_ack), .ack_idx(ack_idx),
        .alternate_table_select(alt_sel), .cpu_prio(cpu_prio), .cpu_ack(cpu_ack), .cpu_return(cpu_return),
        .cpu_irq(cpu_irq), .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_is_trap(vec_is_trap),
        .vec_is_reset(vec_is_reset), .vec_idx(vec_idx), .ret_done(ret_done), .busy(busy));

    ivc_cpu_model u_ivc_cpu_model (.clk(clk), .rstn(rstn), .cpu_irq(cpu_irq), .vec_valid(vec_valid),
        .vec_is_reset(vec_is_reset), .cpu_ack(cpu_ack), .cpu_return(cpu_return), .ack_wait(ack_wait),
        .svc_len(svc_len));

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic do_reset();
        rstn = 1'b0;
        repeat (10) @(negedge clk);
        chk_bit(cpu_irq, 1'b0);
        chk_bit(busy, 1'b0);
        rstn = 1'b1;
        @(negedge clk);
        chk_bit(vec_valid, 1'b1);
        chk_bit(vec_is_reset, 1'b1);
        chk_val(vec_addr, 24'h000000);
        @(negedge clk);
        chk_bit(vec_valid, 1'b0);
    endtask

    // wait for a take, then follow entry and return of one source
    task automatic serve(input logic t, input logic [6:0] i, input logic [23:0] a);
        int n;
        n = 0;
        while ((irq_ack | trap_ack) !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk_bit(trap_ack, t);
        chk_bit(irq_ack, !t);
        chk_bit(busy, 1'b1);
        chk_val({17'h0, ack_idx}, {17'h0, i});
        irq_req = '0;
        trap_req = 8'h00;
        n = 0;
        while (vec_valid !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        chk_val(24'(n), 24'h000004);
        chk_val(vec_addr, a);
        chk_bit(vec_is_trap, t);
        chk_bit(vec_is_reset, 1'b0);
        chk_val({17'h0, vec_idx}, {17'h0, i});
        n = 0;
        while (cpu_return !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (ret_done !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        // counted from the cycle in which the return request stands, one before it is taken
        chk_val(24'(n), 24'(ivc_pkg::RETURN_CYCLES) + 24'h000001);
        chk_bit(busy, 1'b0);
        repeat (2) @(negedge clk);
    endtask

    task automatic quiet();
        repeat (6) @(negedge clk);
        chk_bit(cpu_irq, 1'b0);
        chk_bit(busy, 1'b0);
        irq_req = '0;
        trap_req = 8'h00;
        @(negedge clk);
    endtask

    task automatic test_each_irq();
        for (int i = 0; i < 30; i++)
        begin
            irq_req[i] = 1'b1;
            irq_level[i] = 3'(i % 7 + 1);
            alt_sel = i[0];
            if (IMPL_SET[i])
                serve(1'b0, 7'(i), (i[0] ? 24'h000114 : 24'h000014) + 24'(2 * i));
            else
                quiet();
        end
    endtask

    task automatic test_each_trap();
        for (int s = 0; s < 8; s++)
        begin
            trap_req[s] = 1'b1;
            alt_sel = s[0];
            if (s >= 1 && s <= 4)
                serve(1'b1, 7'(s), (s[0] ? 24'h000104 : 24'h000004) + 24'(2 * s));
            else
                quiet();
        end
        alt_sel = 1'b0;
    endtask

    task automatic test_priority();
        irq_level[0] = 3'h2;
        irq_level[20] = 3'h5;
        irq_req[0] = 1'b1;
        irq_req[20] = 1'b1;
        serve(1'b0, 7'd20, 24'h00003c);
        irq_level[12] = 3'h3;
        irq_level[5] = 3'h3;
        irq_req[12] = 1'b1;
        irq_req[5] = 1'b1;
        serve(1'b0, 7'd5, 24'h00001e);
        irq_level[0] = 3'h7;
        irq_req[0] = 1'b1;
        trap_req[4] = 1'b1;
        serve(1'b1, 7'd4, 24'h00000c);
        trap_req[3:2] = 2'b11;
        serve(1'b1, 7'd2, 24'h000008);
    endtask

    task automatic test_cpu_level();
        irq_level[3] = 3'h2;
        irq_req[3] = 1'b1;
        cpu_prio = 3'h2;
        quiet();
        irq_req[3] = 1'b1;
        cpu_prio = 3'h1;
        ack_wait = 4'h3;
        svc_len = 4'h6;
        serve(1'b0, 7'd3, 24'h00001a);
        cpu_prio = 3'h7;
        trap_req[1] = 1'b1;
        serve(1'b1, 7'd1, 24'h000006);
        cpu_prio = 3'h0;
        ack_wait = 4'h0;
        svc_len = 4'h1;
    endtask

    initial
    begin
        do_reset();
        test_each_irq();
        test_each_trap();
        test_priority();
        test_cpu_level();
        do_reset();
        test_priority();
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule
